// ===== hdl/tbmb_bp.sv
// backplane source end: divides pclk into the link clocks, sends multiplexed words
`timescale 1ns/1ps
module tbmb_bp
    import tbmb_pkg::*;
#(
    parameter int HS_HALF = HS_HALF_DEF
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    tbmb_link_if.bp link,
    input wire logic h100_mode,
    input wire logic [NUM_CH*BYTE_W-1:0] word_in,
    input wire logic word_valid,
    output logic word_take
);
    logic [7:0] div_q;
    logic hs_q;
    logic half_end;
    logic hs_fall;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] nxt;
    logic [CNT_W-1:0] lead;
    logic [NUM_CH*BYTE_W-1:0] sr_q;
    logic [NUM_CH*BYTE_W-1:0] word;
    logic data_q;
    logic sync_q;
    logic ser_q;

    assign half_end = (div_q == 8'(HS_HALF - 1));
    assign hs_fall = half_end && hs_q;
    assign nxt = CNT_W'(cnt_q + 1'b1);
    assign word = word_valid ? word_in : '0;
    assign lead = h100_mode ? LEAD_H100 : LEAD_HMVIP;

    // high-speed clock made here by division
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 8'h00;
            hs_q <= 1'b0;
        end else if (ce) begin
            div_q <= half_end ? 8'h00 : 8'(div_q + 1'b1);
            if (half_end) begin
                hs_q <= !hs_q;
            end
        end
    end

    // change data on the falling edge so the rising edge sees it settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= FRAME_LAST;
            sr_q <= '0;
            data_q <= 1'b0;
            sync_q <= 1'b0;
            ser_q <= 1'b0;
        end else if (ce && hs_fall) begin
            cnt_q <= nxt;
            if (nxt[4:0] == 5'h00) begin
                sr_q <= {word[NUM_CH*BYTE_W-2:0], 1'b0};
                data_q <= word[NUM_CH*BYTE_W-1];
            end else begin
                sr_q <= {sr_q[NUM_CH*BYTE_W-2:0], 1'b0};
                data_q <= sr_q[NUM_CH*BYTE_W-1];
            end
            sync_q <= (nxt < lead) || (nxt >= CNT_W'(FRAME_HS - lead));
            // serial clock is the high-speed clock divided by eight
            ser_q <= !nxt[SER_CLK_BIT];
        end
    end

    assign word_take = ce && hs_fall && nxt[4:0] == 5'h00 && word_valid;
    assign link.tx_hs_clock_in = hs_q;
    assign link.tx_frame_sync = sync_q;
    assign link.tx_serial_data_in = data_q;
    assign link.tx_serial_clock = ser_q;
endmodule : tbmb_bp

// ===== hdl/tbmb_dev.sv
// transmit interface end: apb registers, byte demultiplexer, pattern routing
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module tbmb_dev
    import tbmb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    tbmb_link_if.dev link,
    output logic [NUM_CH*BYTE_W-1:0] line_bytes,
    output logic [NUM_CH-1:0] line_valid,
    output logic tx_gen_en,
    output logic rx_chk_en,
    output logic rx_gen_en,
    output logic tx_chk_en,
    input wire logic tx_chk_lock,
    input wire logic rx_chk_lock,
    output logic irq
);
    logic [TRANSMIT_INTERFACE_CONTROL_W-1:0] transmit_interface_control_q;
    logic [PAT_W-1:0] pat_q;
    logic [EV_W-1:0] stat_q;
    logic [EV_W-1:0] mask_q;
    logic [EV_W-1:0] ev_set;
    logic [DATA_W-1:0] prdata_q;
    logic wr_en;
    logic mapped;
    logic [LIVE_W-1:0] live;
    tbmb_speed_t speed;
    logic mux_active;
    logic h100;
    logic [CNT_W-1:0] lead;
    logic [1:0] hs_s_q;
    logic hs_prev_q;
    logic [1:0] sync_s_q;
    logic [1:0] data_s_q;
    logic hs_rise;
    logic sync_prev_q;
    logic sync_fall;
    tbmb_dmx_t state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] idx;
    logic [BYTE_W-2:0] sr_q;
    logic take_bit;
    logic byte_done;
    logic [BYTE_W-1:0] byte_val;
    logic [CH_W-1:0] ch_idx;
    logic lock_sel;
    logic lock_q;

    // apb: zero wait states, so the access phase always completes
    assign pready = 1'b1;
    assign mapped = (paddr == OFS_TX_IFACE) || (paddr == OFS_PATTERN) || (paddr == OFS_STATUS)
        || (paddr == OFS_MASK) || (paddr == OFS_LIVE);
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign prdata = prdata_q;

    // speed decode depends on multiplex enable
    assign speed = tbmb_speed_t'(transmit_interface_control_q[SPEED_LSB +: SPEED_W]);
    // reserved codes leave the demultiplexer idle
    assign mux_active = transmit_interface_control_q[MUXEN_BIT] && (speed == SPD_HMVIP || speed == SPD_H100);
    // code 11 means the narrow convention only with multiplexing on
    assign h100 = transmit_interface_control_q[MUXEN_BIT] && (speed == SPD_H100);
    // sync width fixes where the frame starts
    assign lead = h100 ? LEAD_H100 : LEAD_HMVIP;
    assign live = {h100, lock_q, state_q == DMX_RUN};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_interface_control_q <= TRANSMIT_INTERFACE_CONTROL_RST;
        end else if (ce && wr_en && paddr == OFS_TX_IFACE) begin
            transmit_interface_control_q <= pwdata[TRANSMIT_INTERFACE_CONTROL_W-1:0];
        end
    end

    // upper nibble neither stored nor read back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pat_q <= PAT_RST;
        end else if (ce && wr_en && paddr == OFS_PATTERN) begin
            pat_q <= pwdata[PAT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= EV_RST;
        end else if (ce && wr_en && paddr == OFS_MASK) begin
            mask_q <= pwdata[EV_W-1:0];
        end
    end

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= EV_RST;
        end else if (ce) begin
            if (wr_en && paddr == OFS_STATUS) begin
                stat_q <= (stat_q & ~pwdata[EV_W-1:0]) | ev_set;
            end else begin
                stat_q <= stat_q | ev_set;
            end
        end
    end

    // read data captured in the setup phase, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (ce && psel && !penable) begin
            unique case (paddr)
                OFS_TX_IFACE: prdata_q <= DATA_W'(transmit_interface_control_q);
                OFS_PATTERN: prdata_q <= DATA_W'(pat_q);
                OFS_STATUS: prdata_q <= DATA_W'(stat_q);
                OFS_MASK: prdata_q <= DATA_W'(mask_q);
                OFS_LIVE: prdata_q <= DATA_W'(live);
                default: prdata_q <= '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(stat_q & mask_q);
        end
    end

    // high-speed clock arrives on the repurposed pin; two flops first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_s_q <= 2'h0;
            sync_s_q <= 2'h0;
            data_s_q <= 2'h0;
            hs_prev_q <= 1'b0;
        end else if (ce) begin
            hs_s_q <= {hs_s_q[0], link.tx_hs_clock_in};
            sync_s_q <= {sync_s_q[0], link.tx_frame_sync};
            data_s_q <= {data_s_q[0], link.tx_serial_data_in};
            hs_prev_q <= hs_s_q[1];
        end
    end

    // sample data and sync on the rising edge of the high-speed clock
    assign hs_rise = hs_s_q[1] && !hs_prev_q;
    assign sync_fall = hs_rise && sync_prev_q && !sync_s_q[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_prev_q <= 1'b0;
        end else if (ce && hs_rise) begin
            sync_prev_q <= sync_s_q[1];
        end
    end

    // first low sync sample is bit 'lead' of the frame
    assign idx = sync_fall ? lead : cnt_q;
    assign take_bit = hs_rise && mux_active && (sync_fall || state_q == DMX_RUN);
    assign byte_done = take_bit && (idx[2:0] == 3'h7);
    assign byte_val = {sr_q, data_s_q[1]};
    assign ch_idx = idx[3 +: CH_W];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= DMX_HUNT;
        end else if (ce) begin
            unique case (state_q)
                DMX_HUNT: if (mux_active && sync_fall) state_q <= DMX_RUN;
                DMX_RUN: if (!mux_active) state_q <= DMX_HUNT;
            endcase
        end
    end

    // bit counter wraps with the 2048-bit multiplexed frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            sr_q <= '0;
        end else if (ce && take_bit) begin
            cnt_q <= CNT_W'(idx + 1'b1);
            sr_q <= byte_val[BYTE_W-2:0];
        end
    end

    // sync edge off its expected slot: flag and realign
    assign ev_set[EV_ALIGN] = ce && sync_fall && mux_active && state_q == DMX_RUN && cnt_q != lead;

    // byte k of the frame goes to line channel k mod 4
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    line_bytes[g*BYTE_W +: BYTE_W] <= '0;
                    line_valid[g] <= 1'b0;
                end else if (ce) begin
                    line_valid[g] <= byte_done && ch_idx == CH_W'(g);
                    if (byte_done && ch_idx == CH_W'(g)) begin
                        line_bytes[g*BYTE_W +: BYTE_W] <= byte_val;
                    end
                end
            end
        end
    endgenerate

    // swap set: receive side generates, transmit side checks
    assign rx_gen_en = pat_q[SWAP_BIT];
    assign tx_chk_en = pat_q[SWAP_BIT];
    // swap clear: transmit side generates, receive side checks
    assign tx_gen_en = !pat_q[SWAP_BIT];
    assign rx_chk_en = !pat_q[SWAP_BIT];
    assign lock_sel = pat_q[SWAP_BIT] ? tx_chk_lock : rx_chk_lock;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'b0;
        end else if (ce) begin
            lock_q <= lock_sel;
        end
    end

    // lock acquisition is a sticky event
    assign ev_set[EV_LOCK] = ce && lock_sel && !lock_q;
endmodule : tbmb_dev

// ===== hdl/tbmb_link_if.sv
// backplane link between the multiplexing source and the transmit interface
`timescale 1ns/1ps
interface tbmb_link_if;
    logic tx_serial_clock;
    logic tx_hs_clock_in;
    logic tx_frame_sync;
    logic tx_serial_data_in;
    modport dev (
        input tx_serial_clock,
        input tx_hs_clock_in,
        input tx_frame_sync,
        input tx_serial_data_in
    );
    modport bp (
        output tx_serial_clock,
        output tx_hs_clock_in,
        output tx_frame_sync,
        output tx_serial_data_in
    );
endinterface : tbmb_link_if

// ===== hdl/tbmb_pkg.sv
// constants, field layout and types shared by both ends of the multiplexed transmit backplane
package tbmb_pkg;
    // register map, byte addresses on apb
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_TX_IFACE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PATTERN = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LIVE = 8'h10;
    localparam int DATA_W = 32;
    // transmit interface control fields
    localparam int SPEED_LSB = 0;
    localparam int SPEED_W = 2;
    localparam int MUXEN_BIT = 2;
    localparam int TRANSMIT_INTERFACE_CONTROL_W = 3;
    localparam logic [TRANSMIT_INTERFACE_CONTROL_W-1:0] TRANSMIT_INTERFACE_CONTROL_RST = 3'h0;
    // pattern control fields; bits 7-4 are not stored
    localparam int SWAP_BIT = 3;
    localparam int PAT_W = 4;
    localparam logic [PAT_W-1:0] PAT_RST = 4'h0;
    // sticky event bits, mask has the same layout
    localparam int EV_LOCK = 0;
    localparam int EV_ALIGN = 1;
    localparam int EV_W = 2;
    localparam logic [EV_W-1:0] EV_RST = 2'h0;
    // live state bits
    localparam int LIVE_RUN = 0;
    localparam int LIVE_LOCK = 1;
    localparam int LIVE_H100 = 2;
    localparam int LIVE_W = 3;
    typedef enum logic [1:0] {
        SPD_RSV0 = 2'b00,
        SPD_RSV1 = 2'b01,
        SPD_HMVIP = 2'b10,
        SPD_H100 = 2'b11
    } tbmb_speed_t;
    typedef enum logic {
        DMX_HUNT = 1'b0,
        DMX_RUN = 1'b1
    } tbmb_dmx_t;
    // stream structure
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int BYTE_W = 8;
    localparam int HS_PER_E1 = 8;
    localparam int FRAME_HS = 2048;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] LEAD_HMVIP = 11'h010;
    localparam logic [CNT_W-1:0] LEAD_H100 = 11'h008;
    localparam logic [CNT_W-1:0] FRAME_LAST = 11'h7FF;
    localparam int SER_CLK_BIT = 2;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int HS_PERIOD_NS = 400;
    localparam int HS_HALF_DEF = HS_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage : tbmb_pkg

// ===== verif/tbmb_link_assertions.sv
// assertions on the backplane link wires
`timescale 1ns/1ps
module tbmb_link_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic h100_mode,
    input wire logic tx_serial_clock,
    input wire logic tx_hs_clock_in,
    input wire logic tx_frame_sync,
    input wire logic tx_serial_data_in
);
    logic hs_q, sy_q, seen_q;
    logic [5:0] hi_q;
    logic [11:0] fr_q;
    // first frame after reset has no tail, so period check waits one sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_q <= 1'b0;
            sy_q <= 1'b0;
            seen_q <= 1'b0;
            hi_q <= 6'h00;
            fr_q <= 12'h000;
        end else begin
            hs_q <= tx_hs_clock_in;
            sy_q <= tx_frame_sync;
            seen_q <= seen_q | (tx_frame_sync & ~sy_q);
            hi_q <= tx_frame_sync ? hi_q + 6'(tx_hs_clock_in & ~hs_q) : 6'h00;
            fr_q <= (tx_frame_sync & ~sy_q) ? 12'h000 : fr_q + 12'(tx_hs_clock_in & ~hs_q);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    // a frozen link stretches every timing window, so those attempts are dropped
    default disable iff (!presetn || !ce);
    a_sync_wide_span: assert property (
        $fell(tx_frame_sync) && !h100_mode |-> hi_q == 6'h20 || hi_q == 6'h10) else $error("wide sync span wrong");
    a_sync_narrow_span: assert property (
        $fell(tx_frame_sync) && h100_mode |-> hi_q == 6'h10 || hi_q == 6'h08) else $error("narrow sync span wrong");
    a_frame_hs_count: assert property (
        $rose(tx_frame_sync) && seen_q |-> fr_q == 12'h800) else $error("frame length wrong");
    a_hs_high_time: assert property (
        $rose(tx_hs_clock_in) |-> tx_hs_clock_in[*4] ##1 !tx_hs_clock_in) else $error("hs high time wrong");
    a_hs_low_time: assert property (
        $fell(tx_hs_clock_in) |-> !tx_hs_clock_in[*4] ##1 tx_hs_clock_in) else $error("hs low time wrong");
    a_data_setup_rise: assert property (
        $rose(tx_hs_clock_in) |-> $stable(tx_serial_data_in) && $stable(tx_frame_sync)) else $error("data moved at rise");
    a_data_hold_high: assert property (
        $rose(tx_hs_clock_in) |=> ($stable(tx_serial_data_in) && $stable(tx_frame_sync))[*3])
        else $error("data moved while hs high");
    a_serclk_half_period: assert property (
        $changed(tx_serial_clock) |-> ##32 $changed(tx_serial_clock)) else $error("serial clock period wrong");
    c_wide_sync: cover property ($fell(tx_frame_sync) && !h100_mode);
    c_narrow_sync: cover property ($fell(tx_frame_sync) && h100_mode);
    c_full_frame: cover property ($rose(tx_frame_sync) && seen_q);
endmodule : tbmb_link_assertions

// ===== verif/tx_backplane_mux_bit_error_tester_route_tb_top.sv
// bench joining the backplane source and transmit interface ends
`timescale 1ns/1ps
module tx_backplane_mux_bit_error_tester_route_tb_top;
    import tbmb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, word_in;
    logic [31:0] line_bytes;
    logic [3:0] line_valid;
    logic tx_gen_en, rx_chk_en, rx_gen_en, tx_chk_en, tx_chk_lock, rx_chk_lock, irq, h100_mode, word_valid;
    logic ce;
    int err_total, n_checks;
    tbmb_link_if link ();
    tbmb_bp #(.HS_HALF(4)) i_tbmb_bp (.pclk(pclk), .presetn(presetn), .ce(ce), .link(link),
        .h100_mode(h100_mode), .word_in(word_in), .word_valid(word_valid), .word_take());
    tbmb_dev i_tbmb_dev (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(link), .line_bytes(line_bytes), .line_valid(line_valid), .tx_gen_en(tx_gen_en),
        .rx_chk_en(rx_chk_en), .rx_gen_en(rx_gen_en), .tx_chk_en(tx_chk_en), .tx_chk_lock(tx_chk_lock),
        .rx_chk_lock(rx_chk_lock), .irq(irq));
    tbmb_link_assertions i_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .h100_mode(h100_mode),
        .tx_serial_clock(link.tx_serial_clock), .tx_hs_clock_in(link.tx_hs_clock_in),
        .tx_frame_sync(link.tx_frame_sync), .tx_serial_data_in(link.tx_serial_data_in));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // waits for pready, never assumes the slave latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // only the watchdog ends a wait for pready
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        check(nm, r, e);
    endtask : rdc
    task automatic do_reset(input logic h100);
        presetn <= 1'b0;
        h100_mode <= h100;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task automatic t_regs;
        rdc("tx_iface", OFS_TX_IFACE, 32'h0);
        rdc("mask", OFS_MASK, 32'h0);
        wr(OFS_PATTERN, 32'hFF);
        rdc("pattern", OFS_PATTERN, 32'h0F);
        check("route swap", 32'({tx_gen_en, rx_chk_en, rx_gen_en, tx_chk_en}), 32'h3);
        wr(OFS_PATTERN, 32'h00);
        @(posedge pclk);
        check("route plain", 32'({tx_gen_en, rx_chk_en, rx_gen_en, tx_chk_en}), 32'hC);
        rdc("unmapped", 8'h14, 32'h0);
        check("slverr", 32'(err_q), 32'h1);
    endtask : t_regs
    task automatic t_irq;
        rx_chk_lock <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc("lock event", OFS_STATUS, 32'h1);
        check("irq masked", 32'(irq), 32'h0);
        wr(OFS_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq raised", 32'(irq), 32'h1);
        wr(OFS_STATUS, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq cleared", 32'(irq), 32'h0);
        wr(OFS_PATTERN, 32'h8);
        rx_chk_lock <= 1'b0;
        repeat (3) @(posedge pclk);
        rx_chk_lock <= 1'b1;
        rdc("other lock ignored", OFS_STATUS, 32'h0);
        tx_chk_lock <= 1'b1;
        rdc("tx lock event", OFS_STATUS, 32'h1);
        tx_chk_lock <= 1'b0;
        rx_chk_lock <= 1'b0;
        wr(OFS_STATUS, 32'h1);
        wr(OFS_MASK, 32'h0);
    endtask : t_irq
    // clock enable low must freeze both ends, events included
    task automatic t_freeze;
        logic hs0;
        ce <= 1'b0;
        rx_chk_lock <= 1'b1;
        repeat (2) @(posedge pclk);
        hs0 = link.tx_hs_clock_in;
        repeat (12) @(posedge pclk);
        check("frozen hs", 32'(link.tx_hs_clock_in), 32'(hs0));
        ce <= 1'b1;
        rx_chk_lock <= 1'b0;
        @(posedge pclk);
        rdc("frozen lock event", OFS_STATUS, 32'h0);
    endtask : t_freeze
    // reserved codes and mux off must leave the demux silent
    task automatic t_idle;
        logic [2:0] codes [3] = '{3'h4, 3'h5, 3'h3};
        int i, seen;
        for (i = 0; i < 3; i++) begin
            do_reset(1'b0);
            wr(OFS_TX_IFACE, 32'(codes[i]));
            seen = 0;
            repeat (3000) begin
                @(posedge pclk);
                if (line_valid !== 4'h0) seen++;
            end
            check("idle valids", 32'(seen), 32'h0);
            rdc("idle live", OFS_LIVE, 32'h0);
        end
    endtask : t_idle
    task automatic t_mode(input logic [2:0] code, input logic h100, input logic [31:0] live);
        int n, g, cyc;
        do_reset(h100);
        cyc = 0;
        while (link.tx_frame_sync !== 1'b1 && cyc < 500) begin
            @(posedge pclk);
            cyc++;
        end
        n = 0;
        while (link.tx_frame_sync === 1'b1 && n < 500) begin
            @(posedge pclk);
            n++;
        end
        // first frame carries only the leading sync half, 8 pclk per hs bit
        check("lead sync", 32'(n), h100 ? 32'h40 : 32'h80);
        wr(OFS_TX_IFACE, 32'(code));
        n = 0;
        cyc = 0;
        while (n < 8 && cyc < 20000) begin
            @(posedge pclk);
            cyc++;
            for (g = 0; g < NUM_CH; g++) begin
                if (line_valid[g] === 1'b1) begin
                    check("line byte", 32'(line_bytes[8*g +: 8]), 32'(word_in[31-8*g -: 8]));
                    n++;
                end
            end
        end
        check("bytes seen", 32'(n), 32'h8);
        rdc("live", OFS_LIVE, live);
        rdc("no misalign", OFS_STATUS, 32'h0);
    endtask : t_mode
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx_chk_lock = 1'b0;
        rx_chk_lock = 1'b0;
        word_in = 32'hA53C960F;
        word_valid = 1'b1;
        h100_mode = 1'b0;
        ce = 1'b1;
        presetn = 1'b0;
        err_total = 0;
        n_checks = 0;
        do_reset(1'b0);
        t_regs;
        t_freeze;
        t_irq;
        t_idle;
        t_mode(3'h6, 1'b0, 32'h1);
        t_mode(3'h7, 1'b1, 32'h5);
        final_report;
    end
    initial begin
        repeat (70000) @(posedge pclk);
        err_total++;
        final_report;
    end
endmodule : tx_backplane_mux_bit_error_tester_route_tb_top
